/* File: verilog/ocf_cfg.svh */
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH

// Command codes of the fault settings
`define OCF_CMD_TRIP        8'h46
`define OCF_CMD_REACT       8'h47
`define OCF_CMD_FLOOR       8'h48

// Reset values
`define OCF_TRIP_RST        16'hffff
`define OCF_REACT_RST       8'hc0
`define OCF_FLOOR_RST       16'h0000

// Field positions in the reaction byte
`define OCF_RESP_HI         7
`define OCF_RESP_LO         6
`define OCF_RETRY_HI        5
`define OCF_RETRY_LO        3
`define OCF_DLY_HI          2
`define OCF_DLY_LO          0

// Reaction codes
`define OCF_RESP_BRICK      2'h0
`define OCF_RESP_COND       2'h1
`define OCF_RESP_DELAY      2'h2
`define OCF_RESP_OFF        2'h3

// Retry codes
`define OCF_RETRY_NONE      3'h0
`define OCF_RETRY_FOREVER   3'h7

`define OCF_BYTE_MASK       16'h00ff
`define OCF_ZERO16          16'h0000

`endif

/* File: verilog/ocf_pkg.sv */
package ocf_pkg;

   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } ocf_cmd_t;

   typedef struct packed
   {
      logic [15:0] trip;
      logic [7:0]  react;
      logic [15:0] floor;
   } ocf_cfg_t;

   typedef enum logic [2:0]
   {
      OCF_ST_OFF     = 3'h0,
      OCF_ST_RUN     = 3'h1,
      OCF_ST_LIMIT   = 3'h2,
      OCF_ST_WAIT    = 3'h3,
      OCF_ST_LATCHED = 3'h4
   } ocf_state_t;

endpackage

/* File: verilog/ocf_delay_timer.sv */
`timescale 1ns/100ps
`include "ocf_cfg.svh"

// Counts 2**code time units, each unit lasting unit_cycles_i clocks
module ocf_delay_timer
#(
   parameter int UW = 16
)
(
   input  wire logic          clock_i,
   input  wire logic          rst_i,
   input  wire logic          start_i,
   input  wire logic [2:0]    code_i,
   input  wire logic [UW-1:0] unit_cycles_i,
   output logic               busy_o,
   output logic               done_o
);

   logic [UW-1:0] pre_reg;
   logic [UW-1:0] pre_next;
   logic [7:0]    units_reg;
   logic [7:0]    units_next;
   logic          busy_reg;
   logic          busy_next;
   logic          done_reg;
   logic          done_next;
   logic          unit_end;

   assign unit_end = (pre_reg >= unit_cycles_i - UW'(1));

   always_comb
   begin
      pre_next   = pre_reg;
      units_next = units_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      if (start_i)
      begin
         pre_next   = '0;
         units_next = 8'h01 << code_i;
         busy_next  = 1'b1;
      end
      else if (busy_reg)
      begin
         if (unit_end)
         begin
            pre_next   = '0;
            units_next = units_reg - 8'h01;
            if (units_reg == 8'h01)
            begin
               busy_next = 1'b0;
               done_next = 1'b1;
            end
         end
         else
         begin
            pre_next = pre_reg + UW'(1);
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         pre_reg   <= '0;
         units_reg <= 8'h00;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end
      else
      begin
         pre_reg   <= pre_next;
         units_reg <= units_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;

endmodule

/* File: verilog/ocf_reg_port.sv */
`timescale 1ns/100ps
`include "ocf_cfg.svh"

// Holds the three fault settings behind the command port
module ocf_reg_port
(
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire ocf_pkg::ocf_cmd_t cmd_i,
   output ocf_pkg::ocf_cfg_t     cfg_o,
   output logic [15:0]           rdata_o,
   output logic                  ack_o,
   output logic                  known_o
);

   ocf_pkg::ocf_cfg_t cfg_reg;
   ocf_pkg::ocf_cfg_t cfg_next;
   logic [15:0]       rdata_reg;
   logic [15:0]       rdata_next;
   logic              ack_reg;
   logic              known_reg;
   logic              known_next;

   always_comb
   begin
      cfg_next   = cfg_reg;
      rdata_next = `OCF_ZERO16;
      known_next = 1'b1;
      case (cmd_i.code)
         `OCF_CMD_TRIP:
         begin
            rdata_next = cfg_reg.trip;
            if (cmd_i.valid && cmd_i.write)
               cfg_next.trip = cmd_i.wdata;
         end
         `OCF_CMD_REACT:
         begin
            rdata_next = {8'h00, cfg_reg.react};
            if (cmd_i.valid && cmd_i.write)
               cfg_next.react = cmd_i.wdata[7:0];
         end
         `OCF_CMD_FLOOR:
         begin
            rdata_next = cfg_reg.floor;
            if (cmd_i.valid && cmd_i.write)
               cfg_next.floor = cmd_i.wdata;
         end
         default:
         begin
            known_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cfg_reg   <= {`OCF_TRIP_RST, `OCF_REACT_RST, `OCF_FLOOR_RST};
         rdata_reg <= `OCF_ZERO16;
         ack_reg   <= 1'b0;
         known_reg <= 1'b0;
      end
      else
      begin
         cfg_reg   <= cfg_next;
         rdata_reg <= (cmd_i.valid && !cmd_i.write) ? rdata_next : `OCF_ZERO16;
         ack_reg   <= cmd_i.valid;
         known_reg <= cmd_i.valid && known_next;
      end
   end

   assign cfg_o   = cfg_reg;
   assign rdata_o = rdata_reg;
   assign ack_o   = ack_reg;
   assign known_o = known_reg;

endmodule

/* File: verilog/ocf_fault_ctrl.sv */
`timescale 1ns/100ps
`include "ocf_cfg.svh"

// Summary of operation
// - The trip threshold is a 16-bit word held for the host to read and write.
// - Every over-current event sets the sticky fault flag and raises the host alert whatever the reaction.
// - Reaction 00 keeps the output on and limits current at the threshold for as long as the fault lasts.
// - Reaction 01 limits current while the output voltage stays at or above the floor, and shuts down below it.
// - Reaction 10 limits current for the programmed delay and shuts down if still limiting when it ends.
// - Reaction 11 disables the output at once and then follows the retry setting.
// - Retry code 000 keeps the output off until the fault is cleared.
// - Retry codes 001 to 110 allow that many restarts, after which the output stays off until cleared.
// - Restart attempts are spaced by 2**code delay time units, the span that the delay code stands for.
// - Retry code 111 restarts without any limit on the count.
// - Unlimited retrying stops only on an off command, the control pin going low, loss of bias power or another shutdown fault.
// - Delay codes 0 to 7 stand for 1, 2, 4 up to 128 time units of a separately set length.
// - The voltage floor for reaction 01 is its own writable 16-bit word.
module ocf_fault_ctrl
#(
   parameter int UW = 16
)
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire ocf_pkg::ocf_cmd_t cmd_i,
   output logic [15:0]            cmd_rdata_o,
   output logic                   cmd_ack_o,
   output logic                   cmd_known_o,
   input  wire logic [UW-1:0]     delay_unit_cycles_i,
   input  wire logic              on_pin_i,
   input  wire logic              op_on_i,
   input  wire logic              bias_ok_i,
   input  wire logic              other_fault_i,
   input  wire logic              clear_fault_i,
   input  wire logic [15:0]       iout_meas_i,
   input  wire logic [15:0]       vout_meas_i,
   output logic                   output_en_o,
   output logic                   current_limit_o,
   output logic [15:0]            limit_level_o,
   output logic                   oc_fault_flag_o,
   output logic                   alert_o,
   output logic [2:0]             restart_count_o,
   output ocf_pkg::ocf_state_t    state_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Settings

   ocf_pkg::ocf_cfg_t cfg;
   logic [1:0]        resp;
   logic [2:0]        retry;
   logic [2:0]        dly;

   ocf_reg_port u_regs
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .cmd_i   (cmd_i),
      .cfg_o   (cfg),
      .rdata_o (cmd_rdata_o),
      .ack_o   (cmd_ack_o),
      .known_o (cmd_known_o)
   );

   assign resp  = cfg.react[`OCF_RESP_HI:`OCF_RESP_LO];
   assign retry = cfg.react[`OCF_RETRY_HI:`OCF_RETRY_LO];
   assign dly   = cfg.react[`OCF_DLY_HI:`OCF_DLY_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Control pin synchroniser

   logic pin_meta_reg;
   logic pin_sync_reg;

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= on_pin_i;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault conditions

   logic run_ok;
   logic over_current;
   logic under_floor;

   // Any of these stops the output and also ends unlimited retrying
   assign run_ok       = pin_sync_reg && op_on_i && bias_ok_i && !other_fault_i;
   assign over_current = (iout_meas_i > cfg.trip);
   assign under_floor  = (vout_meas_i < cfg.floor);

   ////////////////////////////////////////////////////////////////////////////
   // Delay timer

   logic timer_start;
   logic timer_busy;
   logic timer_done;

   ocf_delay_timer #(.UW(UW)) u_timer
   (
      .clock_i       (clock_i),
      .rst_i         (rst_i),
      .start_i       (timer_start),
      .code_i        (dly),
      .unit_cycles_i (delay_unit_cycles_i),
      .busy_o        (timer_busy),
      .done_o        (timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reaction state machine

   ocf_pkg::ocf_state_t state_reg;
   ocf_pkg::ocf_state_t state_next;
   logic [2:0]          count_reg;
   logic [2:0]          count_next;
   logic                flag_reg;
   logic                flag_next;
   logic                oc_event;
   logic                shut;
   logic                budget_left;

   assign budget_left = (retry == `OCF_RETRY_FOREVER) ||
                        ((retry != `OCF_RETRY_NONE) && (count_reg < retry));

   always_comb
   begin
      state_next  = state_reg;
      count_next  = count_reg;
      timer_start = 1'b0;
      oc_event    = 1'b0;
      shut        = 1'b0;
      case (state_reg)
         ocf_pkg::OCF_ST_OFF:
         begin
            if (run_ok)
            begin
               count_next = 3'h0;
               state_next = ocf_pkg::OCF_ST_RUN;
            end
         end
         ocf_pkg::OCF_ST_RUN:
         begin
            if (over_current)
            begin
               oc_event = 1'b1;
               if (resp == `OCF_RESP_OFF)
               begin
                  shut = 1'b1;
               end
               else if (resp == `OCF_RESP_COND && under_floor)
               begin
                  shut = 1'b1;
               end
               else
               begin
                  timer_start = (resp == `OCF_RESP_DELAY);
                  state_next  = ocf_pkg::OCF_ST_LIMIT;
               end
            end
         end
         ocf_pkg::OCF_ST_LIMIT:
         begin
            if (!over_current)
            begin
               state_next = ocf_pkg::OCF_ST_RUN;
            end
            else
            begin
               case (resp)
                  `OCF_RESP_BRICK:
                  begin
                     state_next = ocf_pkg::OCF_ST_LIMIT;
                  end
                  `OCF_RESP_COND:
                  begin
                     shut = under_floor;
                  end
                  `OCF_RESP_DELAY:
                  begin
                     shut = timer_done || !timer_busy;
                  end
                  default:
                  begin
                     shut = 1'b1;
                  end
               endcase
            end
         end
         ocf_pkg::OCF_ST_WAIT:
         begin
            if (timer_done)
            begin
               // Restart attempt: output comes back on
               if (count_reg != `OCF_RETRY_FOREVER)
                  count_next = count_reg + 3'h1;
               state_next = ocf_pkg::OCF_ST_RUN;
            end
         end
         ocf_pkg::OCF_ST_LATCHED:
         begin
            if (clear_fault_i)
            begin
               count_next = 3'h0;
               state_next = ocf_pkg::OCF_ST_RUN;
            end
         end
         default:
         begin
            state_next = ocf_pkg::OCF_ST_OFF;
         end
      endcase

      if (shut)
      begin
         if (budget_left)
         begin
            timer_start = 1'b1;
            state_next  = ocf_pkg::OCF_ST_WAIT;
         end
         else
         begin
            state_next = ocf_pkg::OCF_ST_LATCHED;
         end
      end

      if (!run_ok)
      begin
         state_next = ocf_pkg::OCF_ST_OFF;
      end
   end

   // Sticky flag: a new event wins over a clear in the same cycle
   always_comb
   begin
      flag_next = flag_reg;
      if (clear_fault_i)
         flag_next = 1'b0;
      if (oc_event)
         flag_next = 1'b1;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg <= ocf_pkg::OCF_ST_OFF;
         count_reg <= 3'h0;
         flag_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
         flag_reg  <= flag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   logic en_reg;
   logic en_next;
   logic lim_reg;
   logic lim_next;

   always_comb
   begin
      en_next  = (state_next == ocf_pkg::OCF_ST_RUN) ||
                 (state_next == ocf_pkg::OCF_ST_LIMIT);
      lim_next = (state_next == ocf_pkg::OCF_ST_LIMIT);
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         en_reg  <= 1'b0;
         lim_reg <= 1'b0;
      end
      else
      begin
         en_reg  <= en_next;
         lim_reg <= lim_next;
      end
   end

   assign output_en_o     = en_reg;
   assign current_limit_o = lim_reg;
   assign limit_level_o   = cfg.trip;
   assign oc_fault_flag_o = flag_reg;
   assign alert_o         = flag_reg;
   assign restart_count_o = count_reg;
   assign state_o         = state_reg;

endmodule

/* File: verification/ocf_host_model.sv */
`timescale 1ns/100ps

// Host side of the command port: one transfer per go pulse, answer captured at the ack edge
module ocf_host_model
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              go_i,
   input  wire logic              write_i,
   input  wire logic [7:0]        code_i,
   input  wire logic [15:0]       wdata_i,
   input  wire logic              ack_i,
   input  wire logic [15:0]       rdata_i,
   input  wire logic              known_i,
   output ocf_pkg::ocf_cmd_t      cmd_o,
   output logic [15:0]            data_o,
   output logic                   known_o,
   output logic                   done_o
);
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cmd_o <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         cmd_o.valid <= go_i;
         // Idle fields keep toggling so nothing relies on stale values
         cmd_o.write <= go_i ? write_i : ~cmd_o.write;
         cmd_o.code <= go_i ? code_i : ~cmd_o.code;
         cmd_o.wdata <= go_i ? wdata_i : ~cmd_o.wdata;
         done_o <= ack_i;
         if (ack_i)
         begin
            data_o <= rdata_i;
            known_o <= known_i;
         end
      end
   end
endmodule

/* File: verification/ocf_fault_ctrl_assertions.sv */
`timescale 1ns/100ps
`include "ocf_cfg.svh"

module ocf_fault_ctrl_checker
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire ocf_pkg::ocf_cmd_t cmd_i,
   input  wire logic              cmd_ack_o,
   input  wire logic              op_on_i,
   input  wire logic              bias_ok_i,
   input  wire logic              other_fault_i,
   input  wire logic [15:0]       iout_meas_i,
   input  wire logic              output_en_o,
   input  wire logic              current_limit_o,
   input  wire logic [15:0]       limit_level_o,
   input  wire logic              oc_fault_flag_o,
   input  wire logic              alert_o,
   input  wire logic [2:0]        restart_count_o,
   input  wire ocf_pkg::ocf_state_t state_o
);
   logic [7:0] react_reg;
   logic       oc_run;

   // Shadow of the reaction byte, seen from the command port
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         react_reg <= `OCF_REACT_RST;
      else if (cmd_i.valid && cmd_i.write && cmd_i.code == `OCF_CMD_REACT)
         react_reg <= cmd_i.wdata[7:0];
   end

   assign oc_run = state_o == ocf_pkg::OCF_ST_RUN && iout_meas_i > limit_level_o && bias_ok_i && op_on_i
                   && !other_fault_i;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_oc_run;
      oc_run;
   endsequence
   sequence s_oc_shut;
      oc_run && react_reg[7:6] == `OCF_RESP_OFF;
   endsequence
   sequence s_wait_start;
      $rose(state_o == ocf_pkg::OCF_ST_WAIT);
   endsequence

   a_ack_next_cycle: assert property (cmd_i.valid |=> cmd_ack_o)
      else $error("command not acknowledged one cycle later");
   a_trip_write_seen: assert property (cmd_i.valid && cmd_i.write && cmd_i.code == `OCF_CMD_TRIP
      |=> limit_level_o == $past(cmd_i.wdata)) else $error("trip word not stored");
   a_alert_follows_flag: assert property (alert_o == oc_fault_flag_o)
      else $error("alert differs from fault flag");
   a_flag_on_fault: assert property (s_oc_run |=> oc_fault_flag_o)
      else $error("fault flag not set on over-current");
   a_brick_stays_on: assert property (state_o == ocf_pkg::OCF_ST_LIMIT && react_reg[7:6] == `OCF_RESP_BRICK
      |-> output_en_o && current_limit_o) else $error("brickwall limiting lost output");
   a_off_at_once: assert property (s_oc_shut |=> !output_en_o)
      else $error("output not disabled at once");
   a_no_retry_latch: assert property (s_oc_shut ##0 react_reg[5:3] == `OCF_RETRY_NONE
      |=> state_o == ocf_pkg::OCF_ST_LATCHED) else $error("no-retry fault did not latch off");
   a_count_in_budget: assert property (react_reg[5:3] != `OCF_RETRY_NONE && react_reg[5:3] != `OCF_RETRY_FOREVER
      |-> restart_count_o <= react_reg[5:3]) else $error("restart count over budget");
   a_wait_bounded: assert property (s_wait_start |-> ##[1:600] state_o != ocf_pkg::OCF_ST_WAIT)
      else $error("restart wait did not end");
   a_bias_loss_off: assert property (!bias_ok_i |-> ##[1:2] !output_en_o)
      else $error("output stayed on without bias");
endmodule

bind ocf_fault_ctrl ocf_fault_ctrl_checker ocf_fault_ctrl_checker_inst
(
   .clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_ack_o(cmd_ack_o), .op_on_i(op_on_i),
   .bias_ok_i(bias_ok_i), .other_fault_i(other_fault_i), .iout_meas_i(iout_meas_i), .output_en_o(output_en_o),
   .current_limit_o(current_limit_o), .limit_level_o(limit_level_o), .oc_fault_flag_o(oc_fault_flag_o),
   .alert_o(alert_o), .restart_count_o(restart_count_o), .state_o(state_o)
);

/* File: verification/tb.sv */
`timescale 1ns/100ps

module tb;
   typedef struct packed
   {
      logic [7:0]          react;
      logic [15:0]         vout;
      logic [9:0]          hold;
      ocf_pkg::ocf_state_t st;
      logic                en;
   } ocf_row_t;

   logic clock_i = 1'b0, rst_i = 1'b1, go = 1'b0, wr = 1'b0, on_pin = 1'b1, op_on = 1'b1, bias_ok = 1'b1;
   logic clear_fault = 1'b0, other_fault = 1'b0, ack, known, en, lim, flag, alert, hknown, done;
   logic [7:0]  code = 8'h00;
   logic [15:0] wdata = 16'h0000, iout = 16'h0100, vout = 16'h2000, unit_cyc = 16'h0004, rdata, level, hdata, rd;
   logic [2:0]  count;
   ocf_pkg::ocf_state_t state;
   ocf_pkg::ocf_cmd_t   cmd;
   int errors = 0, tests_run = 0, n;
   ocf_row_t rows [7] = '{
      '{8'h00, 16'h2000, 10'd10, ocf_pkg::OCF_ST_LIMIT,   1'b1},
      '{8'h40, 16'h2000, 10'd10, ocf_pkg::OCF_ST_LIMIT,   1'b1},
      '{8'h40, 16'h0800, 10'd10, ocf_pkg::OCF_ST_LATCHED, 1'b0},
      '{8'h80, 16'h2000, 10'd2,  ocf_pkg::OCF_ST_LIMIT,   1'b1},
      '{8'h80, 16'h2000, 10'd20, ocf_pkg::OCF_ST_LATCHED, 1'b0},
      '{8'hc0, 16'h2000, 10'd4,  ocf_pkg::OCF_ST_LATCHED, 1'b0},
      '{8'hcf, 16'h2000, 10'd10, ocf_pkg::OCF_ST_WAIT,    1'b0}};

   always #5 clock_i = ~clock_i;

   ocf_host_model ocf_host_model_inst (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .write_i(wr), .code_i(code),
      .wdata_i(wdata), .ack_i(ack), .rdata_i(rdata), .known_i(known), .cmd_o(cmd), .data_o(hdata),
      .known_o(hknown), .done_o(done));

   ocf_fault_ctrl ocf_fault_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd), .cmd_rdata_o(rdata),
      .cmd_ack_o(ack), .cmd_known_o(known), .delay_unit_cycles_i(unit_cyc), .on_pin_i(on_pin), .op_on_i(op_on),
      .bias_ok_i(bias_ok), .other_fault_i(other_fault), .clear_fault_i(clear_fault), .iout_meas_i(iout),
      .vout_meas_i(vout), .output_en_o(en), .current_limit_o(lim), .limit_level_o(level),
      .oc_fault_flag_o(flag), .alert_o(alert), .restart_count_o(count), .state_o(state));

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] c, input logic [15:0] d);
      int k;
      @(posedge clock_i);
      go <= 1'b1;
      wr <= w;
      code <= c;
      wdata <= d;
      @(posedge clock_i);
      go <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 6)
      begin
         @(posedge clock_i);
         k++;
      end
      chk("command answer", 16'h0001, 16'(done));
      if (done !== 1'b1)
         stop_test();
      rd = hdata;
   endtask

   task automatic wait_st(input ocf_pkg::ocf_state_t s, input int limit);
      int k;
      k = 0;
      while (state !== s && k < limit)
      begin
         @(posedge clock_i);
         k++;
      end
      chk("state reached", 16'(s), 16'(state));
      if (state !== s)
         stop_test();
   endtask

   // Cycles spent in the restart wait, counted from the first edge seen in it
   task automatic measure();
      wait_st(ocf_pkg::OCF_ST_WAIT, 10);
      n = 0;
      while (state === ocf_pkg::OCF_ST_WAIT && n < 700)
      begin
         @(posedge clock_i);
         n++;
      end
      chk("wait ended", 16'h0000, 16'(state === ocf_pkg::OCF_ST_WAIT));
      if (state === ocf_pkg::OCF_ST_WAIT)
         stop_test();
   endtask

   task automatic recover();
      iout <= 16'h0100;
      op_on <= 1'b0;
      clear_fault <= 1'b1;
      @(posedge clock_i);
      clear_fault <= 1'b0;
      repeat (3) @(posedge clock_i);
      op_on <= 1'b1;
      wait_st(ocf_pkg::OCF_ST_RUN, 20);
   endtask

   initial
   begin
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      bus(1'b0, 8'h46, 16'h0000);
      chk("trip reset", 16'hffff, rd);
      bus(1'b0, 8'h47, 16'h0000);
      chk("reaction reset", 16'h00c0, rd);
      bus(1'b0, 8'h48, 16'h0000);
      chk("floor reset", 16'h0000, rd);
      bus(1'b1, 8'h4a, 16'h1234);
      bus(1'b0, 8'h4a, 16'h0000);
      chk("unmapped read", 16'h0000, rd);
      chk("unmapped known", 16'h0000, 16'(hknown));
      bus(1'b1, 8'h46, 16'h1000);
      bus(1'b1, 8'h48, 16'h1000);
      bus(1'b0, 8'h46, 16'h0000);
      chk("trip readback", 16'h1000, rd);
      chk("limit level", 16'h1000, level);
      bus(1'b0, 8'h48, 16'h0000);
      chk("floor readback", 16'h1000, rd);
      chk("mapped known", 16'h0001, 16'(hknown));
      wait_st(ocf_pkg::OCF_ST_RUN, 20);
      $display("Register test done");
      foreach (rows[i])
      begin
         bus(1'b1, 8'h47, {8'h00, rows[i].react});
         vout <= rows[i].vout;
         iout <= 16'h2000;
         repeat (rows[i].hold) @(posedge clock_i);
         chk("reaction state", 16'(rows[i].st), 16'(state));
         chk("reaction enable", 16'(rows[i].en), 16'(en));
         chk("reaction limit", 16'(rows[i].st == ocf_pkg::OCF_ST_LIMIT), 16'(lim));
         chk("fault flag", 16'h0001, 16'(alert));
         chk("sticky flag", 16'h0001, 16'(flag));
         recover();
         $display("Reaction row %0d done", i);
      end
      vout <= 16'h2000;
      bus(1'b1, 8'h47, 16'h00c8);
      iout <= 16'h2000;
      measure();
      chk("one-unit spacing", 16'h0001, 16'(n >= 3 && n <= 7));
      wait_st(ocf_pkg::OCF_ST_LATCHED, 10);
      chk("restarts used", 16'h0001, 16'(count));
      chk("latched enable", 16'h0000, 16'(en));
      iout <= 16'h0100;
      clear_fault <= 1'b1;
      @(posedge clock_i);
      clear_fault <= 1'b0;
      wait_st(ocf_pkg::OCF_ST_RUN, 10);
      @(posedge clock_i);
      chk("count after clear", 16'h0000, 16'(count));
      $display("Retry budget test done");
      bus(1'b1, 8'h47, 16'h00fb);
      iout <= 16'h2000;
      repeat (8)
      begin
         measure();
         chk("eight-unit spacing", 16'h0001, 16'(n >= 31 && n <= 35));
      end
      wait_st(ocf_pkg::OCF_ST_WAIT, 10);
      bias_ok <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk("bias loss state", 16'(ocf_pkg::OCF_ST_OFF), 16'(state));
      chk("bias loss enable", 16'h0000, 16'(en));
      bias_ok <= 1'b1;
      recover();
      $display("Unlimited retry test done");
      unit_cyc <= 16'h0002;
      iout <= 16'h2000;
      measure();
      chk("short-unit spacing", 16'h0001, 16'(n >= 15 && n <= 19));
      wait_st(ocf_pkg::OCF_ST_WAIT, 10);
      other_fault <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk("other fault state", 16'(ocf_pkg::OCF_ST_OFF), 16'(state));
      other_fault <= 1'b0;
      wait_st(ocf_pkg::OCF_ST_WAIT, 20);
      on_pin <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk("pin off state", 16'(ocf_pkg::OCF_ST_OFF), 16'(state));
      chk("pin off enable", 16'h0000, 16'(en));
      $display("Stop condition test done");
      on_pin <= 1'b1;
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk("reset state", 16'(ocf_pkg::OCF_ST_OFF), 16'(state));
      chk("reset flag", 16'h0000, 16'(flag));
      chk("reset limit", 16'h0000, 16'(lim));
      rst_i <= 1'b0;
      iout <= 16'h0100;
      bus(1'b0, 8'h46, 16'h0000);
      chk("trip after reset", 16'hffff, rd);
      wait_st(ocf_pkg::OCF_ST_RUN, 20);
      $display("Mid-run reset test done");
      stop_test();
   end
endmodule
